/* File: fpc_top.sv */
// How it works
// - Three 8-bit setup registers, reset 0x62
// - Polarity bit 4 inverts PWM output
// - Codes 000/001/010 pick one temperature source
// - Code 011 runs channel full speed
// - Code 100 disables the channel
// - Code 101 takes faster of local, remote2
// - Code 110 takes fastest of all three
// - Code 111 uses software manual duty
// - Lock bit makes setup registers read-only
`timescale 1ns/100ps
module fpc_top #(
    parameter int NUM_CH = fpc_pkg::NUM_CH,
    parameter int DUTY_W = fpc_pkg::DUTY_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [DUTY_W-1:0] speed_remote1,
    input wire logic [DUTY_W-1:0] speed_local,
    input wire logic [DUTY_W-1:0] speed_remote2,
    output logic [NUM_CH-1:0] pwm_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel capture

    logic aw_held_r;
    logic [9:0] aw_addr_r;
    logic w_held_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic aw_take;
    logic w_take;
    logic wr_go;
    logic [9:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic aw_held_nxt;
    logic w_held_nxt;
    logic bvalid_nxt;

    // Each channel accepted once, then held until the response is given
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_go = (aw_held_r || aw_take) && (w_held_r || w_take);
    assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
    assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
    assign aw_held_nxt = (aw_held_r || aw_take) && !wr_go;
    assign w_held_nxt = (w_held_r || w_take) && !wr_go;
    assign bvalid_nxt = wr_go || (s_axi_bvalid && !s_axi_bready);

    // Ready flags come from flops, built from the next holding and response state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            s_axi_awready <= !aw_held_nxt && !bvalid_nxt;
            s_axi_wready <= !w_held_nxt && !bvalid_nxt;
        end
    end

    // Address and data holding flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            if (aw_take) aw_addr_r <= s_axi_awaddr;
            if (w_take) w_data_r <= s_axi_wdata;
            if (w_take) w_strb_r <= s_axi_wstrb;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode

    logic lock_r;
    logic [fpc_pkg::REG_W-1:0] setup_r [NUM_CH];
    logic [DUTY_W-1:0] duty_man_r [NUM_CH];
    logic [NUM_CH-1:0] hit_setup;
    logic [NUM_CH-1:0] hit_duty;
    logic hit_lock;
    logic hit_status;
    logic wr_known;
    logic [9:0] setup_addr [NUM_CH];
    logic [9:0] duty_addr [NUM_CH];

    assign setup_addr[0] = fpc_pkg::ADDR_CH1_SETUP;
    assign setup_addr[1] = fpc_pkg::ADDR_CH2_SETUP;
    assign setup_addr[2] = fpc_pkg::ADDR_CH3_SETUP;
    assign duty_addr[0] = fpc_pkg::ADDR_DUTY1;
    assign duty_addr[1] = fpc_pkg::ADDR_DUTY2;
    assign duty_addr[2] = fpc_pkg::ADDR_DUTY3;
    assign hit_lock = wr_addr[9:2] == fpc_pkg::ADDR_LOCK[9:2];
    assign hit_status = wr_addr[9:2] == fpc_pkg::ADDR_STATUS[9:2];
    assign wr_known = (|hit_setup) || (|hit_duty) || hit_lock || hit_status;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel registers and PWM

    logic [DUTY_W-1:0] ch_duty [NUM_CH];
    logic [NUM_CH-1:0] ch_active;
    logic [NUM_CH-1:0] ch_on;
    logic [NUM_CH-1:0] pwm_raw;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic setup_we;
            logic [fpc_pkg::REG_W-1:0] setup_nxt;

            assign hit_setup[g] = wr_addr[9:2] == setup_addr[g][9:2];
            assign hit_duty[g] = wr_addr[9:2] == duty_addr[g][9:2];
            // Locked writes are dropped silently
            assign setup_we = wr_go && hit_setup[g] && wr_strb[0] && !lock_r;
            // Unused bit keeps its stored value whatever is written
            assign setup_nxt = (wr_data[7:0] & fpc_pkg::WR_MASK)
                | (setup_r[g] & ~fpc_pkg::WR_MASK);

            // Setup and manual duty storage
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    setup_r[g] <= fpc_pkg::SETUP_RST;
                    duty_man_r[g] <= fpc_pkg::DUTY_RST;
                end else begin
                    if (setup_we) setup_r[g] <= setup_nxt;
                    if (wr_go && hit_duty[g] && wr_strb[0]) duty_man_r[g] <= wr_data[7:0];
                end
            end

            fpc_duty_sel u_sel (
                .control_source_select(setup_r[g][fpc_pkg::SRC_HI:fpc_pkg::SRC_LO]),
                .speed_remote1(speed_remote1),
                .speed_local(speed_local),
                .speed_remote2(speed_remote2),
                .manual_duty(duty_man_r[g]),
                .duty(ch_duty[g]),
                .active(ch_active[g])
            );

            fpc_pwm_gen #(
                .DUTY_W(DUTY_W)
            ) u_pwm (
                .aclk(aclk),
                .aresetn(aresetn),
                .duty(ch_duty[g]),
                .active(ch_active[g]),
                .output_polarity_flip(setup_r[g][fpc_pkg::POL_BIT]),
                .pwm_out(pwm_raw[g])
            );

            assign ch_on[g] = ch_active[g];
        end
    endgenerate

    // Outputs already registered inside each generator
    assign pwm_out = pwm_raw;

    ////////////////////////////////////////////////////////////////////////////////
    // Lock register: set-only until reset

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_r <= 1'b0;
        end else if (wr_go && hit_lock && wr_strb[0] && wr_data[0]) begin
            lock_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write response

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= fpc_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? fpc_pkg::RESP_OKAY : fpc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path

    logic ar_take;
    logic [31:0] rd_val;
    logic rd_known;
    logic [7:0] rd_word;
    logic rvalid_nxt;

    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_word = s_axi_araddr[9:2];
    assign rvalid_nxt = ar_take || (s_axi_rvalid && !s_axi_rready);

    // Address ready registered: open whenever no read answer will be pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_arready <= !rvalid_nxt;
        end
    end

    // Read mux
    always_comb begin
        rd_val = '0;
        rd_known = 1'b1;
        if (rd_word == fpc_pkg::ADDR_CH1_SETUP[9:2]) rd_val[7:0] = setup_r[0];
        else if (rd_word == fpc_pkg::ADDR_CH2_SETUP[9:2]) rd_val[7:0] = setup_r[1];
        else if (rd_word == fpc_pkg::ADDR_CH3_SETUP[9:2]) rd_val[7:0] = setup_r[2];
        else if (rd_word == fpc_pkg::ADDR_DUTY1[9:2]) rd_val[7:0] = duty_man_r[0];
        else if (rd_word == fpc_pkg::ADDR_DUTY2[9:2]) rd_val[7:0] = duty_man_r[1];
        else if (rd_word == fpc_pkg::ADDR_DUTY3[9:2]) rd_val[7:0] = duty_man_r[2];
        else if (rd_word == fpc_pkg::ADDR_LOCK[9:2]) rd_val[0] = lock_r;
        else if (rd_word == fpc_pkg::ADDR_STATUS[9:2]) rd_val[NUM_CH-1:0] = ch_on;
        else rd_known = 1'b0;
    end

    // Read data register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= fpc_pkg::RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_known ? fpc_pkg::RESP_OKAY : fpc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : fpc_top

/* File: fpc_pkg.sv */
package fpc_pkg;
    // Channel count and register widths
    localparam int NUM_CH = 3;
    localparam int REG_W = 8;
    localparam int DUTY_W = 8;
    // Register indices; the byte address of each is its index times four
    localparam logic [7:0] IDX_CH1_SETUP = 8'h5C;
    localparam logic [7:0] IDX_CH2_SETUP = 8'h5D;
    localparam logic [7:0] IDX_CH3_SETUP = 8'h5E;
    localparam logic [9:0] ADDR_CH1_SETUP = {IDX_CH1_SETUP, 2'b00};
    localparam logic [9:0] ADDR_CH2_SETUP = {IDX_CH2_SETUP, 2'b00};
    localparam logic [9:0] ADDR_CH3_SETUP = {IDX_CH3_SETUP, 2'b00};
    // Own registers: lock and per-channel manual duty, plus status
    localparam logic [9:0] ADDR_LOCK = 10'h200;
    localparam logic [9:0] ADDR_DUTY1 = 10'h204;
    localparam logic [9:0] ADDR_DUTY2 = 10'h208;
    localparam logic [9:0] ADDR_DUTY3 = 10'h20C;
    localparam logic [9:0] ADDR_STATUS = 10'h210;
    localparam int ADDR_W = 10;
    // Setup register fields
    localparam int SPIN_LO = 0;
    localparam int SPIN_HI = 2;
    localparam int UNUSED_BIT = 3;
    localparam int POL_BIT = 4;
    localparam int SRC_LO = 5;
    localparam int SRC_HI = 7;
    localparam logic [7:0] SETUP_RST = 8'h62;
    localparam logic [7:0] WR_MASK = 8'hF7;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    // Control source codes
    localparam logic [2:0] SRC_REMOTE1 = 3'h0;
    localparam logic [2:0] SRC_LOCAL = 3'h1;
    localparam logic [2:0] SRC_REMOTE2 = 3'h2;
    localparam logic [2:0] SRC_FULL = 3'h3;
    localparam logic [2:0] SRC_OFF = 3'h4;
    localparam logic [2:0] SRC_MAX_LR2 = 3'h5;
    localparam logic [2:0] SRC_MAX_ALL = 3'h6;
    localparam logic [2:0] SRC_MANUAL = 3'h7;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : fpc_pkg

/* File: fpc_duty_sel.sv */
`timescale 1ns/100ps
// Picks the duty cycle a channel should run at from its source code
module fpc_duty_sel (
    input wire logic [2:0] control_source_select,
    input wire logic [7:0] speed_remote1,
    input wire logic [7:0] speed_local,
    input wire logic [7:0] speed_remote2,
    input wire logic [7:0] manual_duty,
    output logic [7:0] duty,
    output logic active
);
    logic [7:0] max_lr2;
    logic [7:0] max_all;

    // Fastest-of helpers
    assign max_lr2 = (speed_local > speed_remote2) ? speed_local : speed_remote2;
    assign max_all = (max_lr2 > speed_remote1) ? max_lr2 : speed_remote1;

    // Source selection
    always_comb begin
        active = 1'b1;
        case (control_source_select)
            fpc_pkg::SRC_REMOTE1: duty = speed_remote1;
            fpc_pkg::SRC_LOCAL: duty = speed_local;
            fpc_pkg::SRC_REMOTE2: duty = speed_remote2;
            fpc_pkg::SRC_FULL: duty = fpc_pkg::DUTY_FULL;
            fpc_pkg::SRC_OFF: begin
                duty = fpc_pkg::DUTY_RST;
                active = 1'b0;
            end
            fpc_pkg::SRC_MAX_LR2: duty = max_lr2;
            fpc_pkg::SRC_MAX_ALL: duty = max_all;
            fpc_pkg::SRC_MANUAL: duty = manual_duty;
            default: duty = fpc_pkg::DUTY_FULL;
        endcase
    end
endmodule : fpc_duty_sel

/* File: fpc_pwm_gen.sv */
`timescale 1ns/100ps
// Free-running PWM counter with polarity control; output registered
module fpc_pwm_gen #(
    parameter int DUTY_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [DUTY_W-1:0] duty,
    input wire logic active,
    input wire logic output_polarity_flip,
    output logic pwm_out
);
    logic [DUTY_W-1:0] cnt_r;
    logic raw_on;
    logic pwm_nxt;

    // High while counter below duty; all-ones duty means always on
    assign raw_on = active && ((duty == {DUTY_W{1'b1}}) || (cnt_r < duty));
    assign pwm_nxt = raw_on ^ output_polarity_flip;

    // Counter and output flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
            pwm_out <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            pwm_out <= pwm_nxt;
        end
    end
endmodule : fpc_pwm_gen

/* File: fpc_top_assertions.sv */
`timescale 1ns/100ps
module fpc_chk #(
    parameter int NUM_CH = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_CH-1:0] pwm_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Reset release: pins idle first, then every channel at full speed
    sequence s_wake;
        pwm_out == '0 ##1 pwm_out == '1;
    endsequence
    chk_wake_full: assert property ($rose(aresetn) |-> s_wake)
        else $error("channels not at full speed after reset");
    // Bus answers are held and arrive one cycle after the request is taken
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    chk_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_turn: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write answer late");
    chk_resp_gate: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken before response");
    chk_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == fpc_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h00000000)
        else $error("error read carries data");
    chk_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
endmodule : fpc_chk
////////////////////////////////////////////////////////////////////////////////
bind fpc_top fpc_chk #(.NUM_CH(NUM_CH)) i_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pwm_out(pwm_out));

/* File: fpc_fan_model.sv */
`timescale 1ns/100ps
module fpc_fan_model (
    input wire logic aclk,
    input wire logic [2:0] drive_in,
    output logic [2:0][8:0] high_cnt
);
    logic [7:0] win_pos = 8'h00;
    logic [2:0][8:0] acc = '0;
    // Each fan integrates its high drive over a 256-cycle window, like rotor inertia
    always @(posedge aclk) begin
        win_pos <= win_pos + 8'h01;
        for (int i = 0; i < 3; i++) begin
            acc[i] <= (win_pos == 8'hFF) ? 9'h000 : acc[i] + 9'(drive_in[i]);
            if (win_pos == 8'hFF) high_cnt[i] <= acc[i] + 9'(drive_in[i]);
        end
    end
endmodule : fpc_fan_model

/* File: tb_fan_pwm_channel_config.sv */
`timescale 1ns/100ps
module tb_fan_pwm_channel_config;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [9:0] awaddr = 10'h000, araddr = 10'h000;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [7:0] spd_r1 = 8'h00, spd_lo = 8'h00, spd_r2 = 8'h00;
    logic [2:0] pwm_out;
    logic [2:0][8:0] fan_cnt;
    int miscompares = 0;
    int compares = 0;
    int ready_lag = 0;
    localparam logic [7:0] ON_MASK [4] = '{8'hC9, 8'hEA, 8'hEC, 8'h88};
    // 25 MHz clock
    always #20 aclk = ~aclk;
    fpc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .speed_remote1(spd_r1), .speed_local(spd_lo), .speed_remote2(spd_r2), .pwm_out(pwm_out));
    fpc_fan_model i_fan (.aclk(aclk), .drive_in(pwm_out), .high_cnt(fan_cnt));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] exp);
        logic a_hs, w_hs, b_hs;
        logic [1:0] resp;
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= (ready_lag == 0);
        do begin
            @(negedge aclk);
            a_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid && bready;
            resp = bresp;
            @(posedge aclk);
            n++;
            if (a_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (n == ready_lag) bready <= 1'b1;
        end while (!b_hs);
        bready <= 1'b0;
        chk("bresp", {30'h0, resp}, {30'h0, exp});
    endtask : wr
    // Read: request held until taken, data sampled at the falling edge of the handshake cycle
    task automatic rd(input logic [9:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
        logic ar_hs, r_hs;
        logic [31:0] d;
        logic [1:0] resp;
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (ready_lag == 0);
        do begin
            @(negedge aclk);
            ar_hs = arvalid && arready;
            r_hs = rvalid && rready;
            d = rdata;
            resp = rresp;
            @(posedge aclk);
            n++;
            if (ar_hs) arvalid <= 1'b0;
            if (n == ready_lag) rready <= 1'b1;
        end while (!r_hs);
        rready <= 1'b0;
        chk("rdata", d, exp);
        chk("rresp", {30'h0, resp}, {30'h0, exp_resp});
    endtask : rd
    task automatic wrap_up;
        if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] setup;
        logic on;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            rd(fpc_pkg::ADDR_CH1_SETUP + 10'(4 * i), {24'h0, fpc_pkg::SETUP_RST}, 2'h0);
            wr(fpc_pkg::ADDR_DUTY1 + 10'(4 * i), (i == 1) ? 32'h00 : 32'hFF, 2'h0);
            rd(fpc_pkg::ADDR_DUTY1 + 10'(4 * i), (i == 1) ? 32'h00 : 32'hFF, 2'h0);
        end
        rd(10'h3FC, 32'h0, fpc_pkg::RESP_SLVERR);
        wr(10'h3FC, 32'h0, fpc_pkg::RESP_SLVERR);
        // Every source code on every channel, third channel inverted
        for (int c = 0; c < 8; c++) begin
            for (int i = 0; i < 3; i++) begin
                setup = {3'(c), (i == 2), 4'h0};
                wr(fpc_pkg::ADDR_CH1_SETUP + 10'(4 * i), {24'h0, setup}, 2'h0);
                rd(fpc_pkg::ADDR_CH1_SETUP + 10'(4 * i), {24'h0, setup}, 2'h0);
            end
            rd(fpc_pkg::ADDR_STATUS, {29'h0, {3{c != 4}}}, 2'h0);
            for (int k = 0; k < 4; k++) begin
                @(posedge aclk);
                spd_r1 <= (k == 0) ? 8'hFF : 8'h00;
                spd_lo <= (k == 1) ? 8'hFF : 8'h00;
                spd_r2 <= (k == 2) ? 8'hFF : 8'h00;
                repeat (600) @(posedge aclk);
                for (int i = 0; i < 3; i++) begin
                    on = ON_MASK[k][c] && !(i == 1 && c == 7);
                    chk("fan", {23'h0, fan_cnt[i]}, (on ^ (i == 2)) ? 32'h100 : 32'h0);
                end
            end
        end
        // Lock then try to rewrite; a fresh reset restores defaults
        // Answers from here on are accepted late so held responses are seen
        ready_lag = 3;
        wr(fpc_pkg::ADDR_LOCK, 32'h1, 2'h0);
        rd(fpc_pkg::ADDR_LOCK, 32'h1, 2'h0);
        wr(fpc_pkg::ADDR_CH1_SETUP, 32'h80, 2'h0);
        rd(fpc_pkg::ADDR_CH1_SETUP, 32'hE0, 2'h0);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(fpc_pkg::ADDR_CH1_SETUP, {24'h0, fpc_pkg::SETUP_RST}, 2'h0);
        rd(fpc_pkg::ADDR_LOCK, 32'h0, 2'h0);
        wr(fpc_pkg::ADDR_CH1_SETUP, 32'h80, 2'h0);
        rd(fpc_pkg::ADDR_CH1_SETUP, 32'h80, 2'h0);
        wrap_up;
    end
    // Watchdog
    initial begin
        repeat (60000) @(posedge aclk);
        miscompares++;
        wrap_up;
    end
endmodule : tb_fan_pwm_channel_config
